// ### common/uart_map.svh
// register offsets, field positions, reset values and timing counts
// of the serial port control block; included by its bare name
`ifndef UART_MAP_SVH
`define UART_MAP_SVH
// byte offsets on the apb bus
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_DATA 8'h08
`define OFS_BAUD 8'h0C
`define OFS_STATUS 8'h10
`define OFS_IRQ 8'h14
// uart_control_a field positions
`define CA_UART_ON 7
`define CA_NINE_BIT 6
`define CA_SEND_BREAK 2
`define CA_RX_NINTH 1
`define CA_TX_NINTH 0
// status field positions
`define ST_OVERRUN 4
`define ST_RX_IDLE 3
`define ST_RX_FULL 2
`define ST_TX_IDLE 1
`define ST_TX_EMPTY 0
// irq register: request flag, write one to clear
`define IRQ_FLAG 0
// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
// timing counts
`define BREAK_BITS 4'hD
`define OS_LAST 4'hF
`define OS_MID 4'h7
`define PRE_LOW 2'h3
`define PRE_HIGH 2'h0
`endif

// ### common/uart_pkg.sv
// types shared by the serial port control block
// assumes uart_map.svh supplies all numeric constants
package uart_pkg;
   // uart_control_b fields, msb first
   typedef struct packed {
      logic tx_enable_bit;
      logic rx_enable_bit;
      logic baud_high_speed;
      logic addr_detect_en;
      logic wake_en;
      logic rx_irq_en;
      logic tx_idle_irq_en;
      logic tx_empty_irq_en;
   } ctrl_b_t;
   // serial pin drive toward the pad ring
   typedef struct packed {
      logic tx_out;
      logic tx_oe;
      logic rx_ctl;
   } pins_t;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BREAK} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : uart_pkg

// ### hdl/baud_gen.sv
// baud generator: free-running 8-bit timer plus prescale of 4 or 1 set by high_speed
// assumes run drops whenever the port is switched off
`timescale 1ns/1ns
`include "uart_map.svh"
module baud_gen import uart_pkg::*; #(
   parameter int DIV_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic run,
   input wire logic high_speed,
   input wire logic [DIV_W-1:0] divisor,
   // ticks
   output logic os_tick,
   output logic bit_tick
);
   if (DIV_W != 8) begin : g_bad_width
      $error("baud_gen: divisor must be 8 bits");
   end
   logic [DIV_W-1:0] timer_reg;
   logic [1:0] pre_reg;
   logic [3:0] os_reg;
   wire base_tick = (timer_reg == '0);
   wire [1:0] pre_last = high_speed ? `PRE_HIGH : `PRE_LOW;
   wire pre_done = base_tick && (pre_reg >= pre_last);
   // timer reloads N on expiry, so one base tick per N+1 clocks
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         timer_reg <= '0;
         pre_reg <= '0;
         os_reg <= '0;
         os_tick <= 1'b0;
         bit_tick <= 1'b0;
      end else begin
         timer_reg <= base_tick ? divisor : timer_reg - 1'b1; // [RQ10] [RQ21]
         if (base_tick)
            pre_reg <= pre_done ? 2'h0 : pre_reg + 2'h1;
         if (pre_done)
            os_reg <= os_reg + 4'h1;
         os_tick <= pre_done; // 16x rate: 4 or 1 base ticks [RQ8]
         bit_tick <= pre_done && (os_reg == `OS_LAST);
      end
   end
endmodule : baud_gen

// ### hdl/uart_tx.sv
// transmit shifter: start, 8 or 9 data bits lsb first, one stop, break
// assumes bit_tick is a one-cycle pulse at the bit rate
`timescale 1ns/1ns
`include "uart_map.svh"
module uart_tx import uart_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic active,
   input wire logic bit_tick,
   input wire logic nine_bit,
   input wire logic send_break,
   // holding register side
   input wire logic hold_valid,
   input wire logic [8:0] hold_word,
   output logic take,
   // status and line
   output logic busy,
   output logic line
);
   tx_state_t state_reg;
   logic [8:0] shift_reg;
   logic [3:0] cnt_reg;
   wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;
   wire start_data = (state_reg == TX_IDLE) && hold_valid && bit_tick;
   // break only once buffered data has drained
   wire start_brk = (state_reg == TX_IDLE) && !hold_valid && send_break && bit_tick;
   assign busy = (state_reg != TX_IDLE);
   always_ff @(posedge clk) begin
      if (sys_rst || !active) begin // abort and reset [RQ4]
         state_reg <= TX_IDLE;
         shift_reg <= '0;
         cnt_reg <= '0;
         take <= 1'b0;
         line <= 1'b1;
      end else begin
         take <= start_data;
         case (state_reg)
            TX_IDLE: begin
               line <= 1'b1; // rest high [RQ20]
               if (start_data) begin
                  shift_reg <= hold_word; // ninth bit from tx_ninth_bit [RQ3]
                  line <= 1'b0;
                  state_reg <= TX_START;
               end else if (start_brk) begin
                  line <= 1'b0;
                  cnt_reg <= 4'h1;
                  state_reg <= TX_BREAK; // [RQ1]
               end
            end
            TX_START: if (bit_tick) begin
               line <= shift_reg[0];
               shift_reg <= {1'b0, shift_reg[8:1]};
               cnt_reg <= '0;
               state_reg <= TX_DATA;
            end
            TX_DATA: if (bit_tick) begin
               cnt_reg <= cnt_reg + 4'h1;
               if (cnt_reg == last_bit) begin
                  line <= 1'b1;
                  state_reg <= TX_STOP;
               end else begin
                  line <= shift_reg[0];
                  shift_reg <= {1'b0, shift_reg[8:1]};
               end
            end
            TX_STOP: if (bit_tick)
               state_reg <= TX_IDLE;
            TX_BREAK: if (bit_tick) begin
               // low at least 13 bits, then until send_break clears
               if (cnt_reg < `BREAK_BITS)
                  cnt_reg <= cnt_reg + 4'h1;
               else if (!send_break) begin // [RQ1]
                  line <= 1'b1;
                  state_reg <= TX_IDLE;
               end
            end
            default: state_reg <= TX_IDLE;
         endcase
      end
   end
endmodule : uart_tx

// ### hdl/uart_ctrl.sv
// serial port control: apb registers, receiver, address detect, wake-up
// and interrupt request flag; instantiates baud_gen and uart_tx
// assumes an apb master on clk and a pad ring that resolves tx_oe
//
// Contract
// RQ1: with send_break set, drain data, then hold line low 13+ bits until cleared
// RQ2: nine-bit mode stores received ninth bit in rx_ninth_bit
// RQ3: nine-bit mode sends tx_ninth_bit as ninth data bit
// RQ4: tx enable low aborts, resets transmitter and buffer, floats transmit pin
// RQ5: transmitter drives pin only with tx enable and uart_on both set
// RQ6: rx enable low aborts reception, resets receiver and buffer, floats pin
// RQ7: receiver active only with rx enable and uart_on both set
// RQ8: bit rate is clock over 64(N+1) low speed, 16(N+1) high speed
// RQ9: divisor N is unsigned eight bits, zero to 255
// RQ10: baud timing from dedicated free-running eight-bit timer
// RQ11: address detect: address bit one marks address word and may interrupt
// RQ12: address detect: address bit zero discards word, no interrupt
// RQ13: wake enable plus sleep: receive falling edge wakes chip
// RQ14: rx irq enable: overrun or rx full setting sets request flag
// RQ15: tx idle irq enable: tx idle setting sets request flag
// RQ16: tx empty irq enable: tx empty setting sets request flag
// RQ17: one data location: writes transmit, reads return received data
// RQ18: nine-bit frames when nine_bit_select set, else eight-bit
// RQ19: uart_on low floats pins, empties buffer, resets counter, clears bits
// RQ20: tx idle when tx empty and nothing sending; idle line high
// RQ21: baud timer reloads divisor, one tick per (N+1)*64 or *16 clocks
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "uart_map.svh"
module uart_ctrl import uart_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   input wire logic rx_pin,
   output pins_t pins,
   // power management
   input wire logic sleep_mode,
   output logic wake_req,
   // interrupt request flag
   output logic irq_req
);
   // control registers
   logic uart_on_reg;
   logic nine_bit_reg;
   logic send_break_reg;
   logic tx_ninth_reg;
   ctrl_b_t ctrl_b_reg;
   logic [7:0] baud_divisor_reg;
   // transmit buffer
   logic [7:0] tx_hold_reg;
   logic tx_hold_ninth_reg;
   logic hold_valid_reg;
   // receive side
   logic [1:0] rx_sync_reg;
   logic rx_prev_reg;
   rx_state_t rx_state_reg;
   logic [3:0] rx_os_reg;
   logic [3:0] rx_idx_reg;
   logic [8:0] rx_shift_reg;
   logic [7:0] rx_data_reg;
   logic rx_ninth_reg;
   logic rx_full_reg;
   logic overrun_reg;
   logic rx_done_reg;
   // flag history and sequence tracking
   logic status_seen_reg;
   logic tx_idle_prev_reg;
   logic tx_empty_prev_reg;
   logic irq_flag_reg;
   // sub-block wires
   logic os_tick;
   logic bit_tick;
   logic tx_take;
   logic tx_busy;
   logic tx_line;

   // apb decode
   wire acc = psel && penable && !pready;
   wire done = psel && penable && pready;
   wire wr_done = done && pwrite && !pslverr;
   wire rd_done = done && !pwrite && !pslverr;
   wire hit_a = (paddr == `OFS_CTRL_A);
   wire hit_b = (paddr == `OFS_CTRL_B);
   wire hit_data = (paddr == `OFS_DATA);
   wire hit_baud = (paddr == `OFS_BAUD);
   wire hit_stat = (paddr == `OFS_STATUS);
   wire hit_irq = (paddr == `OFS_IRQ);
   wire mapped = hit_a || hit_b || hit_data || hit_baud || hit_stat || hit_irq;
   wire wr_a = wr_done && hit_a;
   wire wr_b = wr_done && hit_b;
   wire wr_data = wr_done && hit_data;
   wire wr_baud = wr_done && hit_baud;
   wire wr_irq = wr_done && hit_irq;
   wire rd_data = rd_done && hit_data;
   wire rd_stat = rd_done && hit_stat;

   // enables qualified by uart_on
   wire tx_active = uart_on_reg && ctrl_b_reg.tx_enable_bit; // [RQ5]
   wire rx_active = uart_on_reg && ctrl_b_reg.rx_enable_bit; // [RQ7]
   wire tx_empty = !hold_valid_reg;
   wire tx_idle = tx_empty && !tx_busy; // [RQ20]
   wire rx_idle = (rx_state_reg == RX_IDLE);
   wire rx_s = rx_sync_reg[1];

   // read mux
   wire [7:0] ctrl_a_rd = {uart_on_reg, nine_bit_reg, 3'b000, send_break_reg,
                           rx_ninth_reg, 1'b0}; // tx_ninth_bit reads zero
   wire [7:0] stat_rd = {3'b000, overrun_reg, rx_idle, rx_full_reg, tx_idle,
                         tx_empty};
   wire [7:0] rd_byte = hit_a ? ctrl_a_rd :
                        hit_b ? ctrl_b_reg :
                        hit_data ? rx_data_reg : // [RQ17]
                        hit_baud ? baud_divisor_reg :
                        hit_stat ? stat_rd :
                        hit_irq ? {7'h00, irq_flag_reg} : `RST_BYTE;

   // apb answer: one wait state so prdata and pready come from flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `RST_WORD;
      end else begin
         pready <= acc;
         pslverr <= acc && !mapped;
         prdata <= (acc && !pwrite) ? {24'h00_0000, rd_byte} : `RST_WORD;
      end
   end

   // uart_control_a
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         uart_on_reg <= 1'b0;
         nine_bit_reg <= 1'b0;
         send_break_reg <= 1'b0;
         tx_ninth_reg <= 1'b0;
      end else if (wr_a) begin
         uart_on_reg <= pwdata[`CA_UART_ON];
         nine_bit_reg <= pwdata[`CA_NINE_BIT]; // [RQ18]
         // break bit cannot be set while the port is off
         send_break_reg <= pwdata[`CA_SEND_BREAK] && pwdata[`CA_UART_ON]; // [RQ19]
         tx_ninth_reg <= pwdata[`CA_TX_NINTH];
      end else if (!uart_on_reg) begin
         send_break_reg <= 1'b0; // [RQ19]
      end
   end

   // uart_control_b; enables drop with uart_on, other bits survive
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_b_reg <= `RST_BYTE;
      end else if (wr_b) begin
         ctrl_b_reg <= pwdata[7:0];
         if (!uart_on_reg) begin
            ctrl_b_reg.tx_enable_bit <= 1'b0; // [RQ19]
            ctrl_b_reg.rx_enable_bit <= 1'b0;
         end
      end else if (!uart_on_reg) begin
         ctrl_b_reg.tx_enable_bit <= 1'b0; // [RQ19]
         ctrl_b_reg.rx_enable_bit <= 1'b0;
      end
   end

   // divisor: full unsigned 0..255
   always_ff @(posedge clk) begin
      if (sys_rst)
         baud_divisor_reg <= `RST_BYTE;
      else if (wr_baud)
         baud_divisor_reg <= pwdata[7:0]; // [RQ9]
   end

   // transmit holding register; writes while full are dropped
   always_ff @(posedge clk) begin
      if (sys_rst || !tx_active) begin // buffer emptied [RQ4] [RQ19]
         hold_valid_reg <= 1'b0;
         tx_hold_reg <= `RST_BYTE;
         tx_hold_ninth_reg <= 1'b0;
      end else if (wr_data && !hold_valid_reg) begin
         tx_hold_reg <= pwdata[7:0]; // [RQ17]
         tx_hold_ninth_reg <= nine_bit_reg && tx_ninth_reg; // [RQ3]
         hold_valid_reg <= 1'b1;
      end else if (tx_take) begin
         hold_valid_reg <= 1'b0;
      end
   end

   // status read arms the clear sequence, data access completes it
   always_ff @(posedge clk) begin
      if (sys_rst)
         status_seen_reg <= 1'b0;
      else if (rd_stat)
         status_seen_reg <= 1'b1;
      else if (done && hit_data)
         status_seen_reg <= 1'b0;
   end

   // receive pin synchroniser; only the second stage is looked at
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_sync_reg <= 2'b11;
         rx_prev_reg <= 1'b1;
      end else begin
         rx_sync_reg <= {rx_sync_reg[0], rx_pin};
         rx_prev_reg <= rx_s;
      end
   end

   // wake-up on falling edge, independent of the receiver enables
   always_ff @(posedge clk) begin
      if (sys_rst)
         wake_req <= 1'b0;
      else
         wake_req <= ctrl_b_reg.wake_en && sleep_mode && rx_prev_reg && !rx_s; // [RQ13]
   end

   // receive frame: 16x oversampling, start verified at mid-bit
   wire [3:0] rx_last = nine_bit_reg ? 4'h8 : 4'h7; // [RQ18]
   always_ff @(posedge clk) begin
      if (sys_rst || !rx_active) begin // abort reception [RQ6] [RQ19]
         rx_state_reg <= RX_IDLE;
         rx_os_reg <= '0;
         rx_idx_reg <= '0;
         rx_shift_reg <= '0;
         rx_done_reg <= 1'b0;
      end else begin
         rx_done_reg <= 1'b0;
         case (rx_state_reg)
            RX_IDLE: if (!rx_s) begin
               rx_os_reg <= '0;
               rx_state_reg <= RX_START;
            end
            RX_START: if (os_tick) begin
               rx_os_reg <= rx_os_reg + 4'h1;
               if (rx_os_reg == `OS_MID) begin
                  // a glitch shorter than half a bit is not a start
                  rx_state_reg <= rx_s ? RX_IDLE : RX_DATA;
                  rx_os_reg <= '0;
                  rx_idx_reg <= '0;
               end
            end
            RX_DATA: if (os_tick) begin
               rx_os_reg <= rx_os_reg + 4'h1;
               if (rx_os_reg == `OS_LAST) begin
                  rx_shift_reg <= {rx_s, rx_shift_reg[8:1]};
                  rx_idx_reg <= rx_idx_reg + 4'h1;
                  if (rx_idx_reg == rx_last)
                     rx_state_reg <= RX_STOP;
               end
            end
            RX_STOP: if (os_tick) begin
               rx_os_reg <= rx_os_reg + 4'h1;
               if (rx_os_reg == `OS_LAST) begin
                  rx_done_reg <= 1'b1;
                  rx_state_reg <= RX_IDLE;
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // eight-bit frames sit in the top of the shifter
   wire [8:0] rx_word = nine_bit_reg ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
   wire addr_bit = nine_bit_reg ? rx_word[8] : rx_word[7];
   wire rx_keep = !ctrl_b_reg.addr_detect_en || addr_bit; // [RQ11] [RQ12]
   wire rx_land = rx_done_reg && rx_keep && !rx_full_reg && !overrun_reg;
   wire ovr_set = rx_done_reg && rx_keep && rx_full_reg;
   wire rx_clear = rd_data && status_seen_reg;

   // receive data register and its flags; set beats clear
   always_ff @(posedge clk) begin
      if (sys_rst || !rx_active) begin // receive buffer reset [RQ6] [RQ19]
         rx_full_reg <= 1'b0;
         overrun_reg <= 1'b0;
      end else begin
         if (ovr_set)
            overrun_reg <= 1'b1;
         else if (rx_clear)
            overrun_reg <= 1'b0;
         if (rx_land)
            rx_full_reg <= 1'b1;
         else if (rx_clear || rd_data)
            rx_full_reg <= 1'b0;
      end
   end

   // data and ninth bit keep their value across disable
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_data_reg <= `RST_BYTE;
         rx_ninth_reg <= 1'b0;
      end else if (rx_land) begin
         rx_data_reg <= rx_word[7:0];
         rx_ninth_reg <= nine_bit_reg && rx_word[8]; // [RQ2]
      end
   end

   // flag histories for rising-edge interrupt events
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_idle_prev_reg <= 1'b1;
         tx_empty_prev_reg <= 1'b1;
      end else begin
         tx_idle_prev_reg <= tx_idle;
         tx_empty_prev_reg <= tx_empty;
      end
   end

   // overrun counts only as it becomes set, not on every later word
   wire rx_irq = ctrl_b_reg.rx_irq_en && ((ovr_set && !overrun_reg) || rx_land); // [RQ14]
   wire idle_irq = ctrl_b_reg.tx_idle_irq_en && tx_idle && !tx_idle_prev_reg; // [RQ15]
   wire empty_irq = ctrl_b_reg.tx_empty_irq_en && tx_empty && !tx_empty_prev_reg; // [RQ16]
   wire irq_set = rx_irq || idle_irq || empty_irq;

   // request flag: write one clears, a same-cycle event wins
   always_ff @(posedge clk) begin
      if (sys_rst)
         irq_flag_reg <= 1'b0;
      else if (irq_set)
         irq_flag_reg <= 1'b1;
      else if (wr_irq && pwdata[`IRQ_FLAG])
         irq_flag_reg <= 1'b0;
   end

   // pin drive registered; disabled ends float
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pins <= '0;
         irq_req <= 1'b0;
      end else begin
         pins.tx_out <= tx_active ? tx_line : 1'b1;
         pins.tx_oe <= tx_active; // [RQ5] [RQ4]
         pins.rx_ctl <= rx_active; // [RQ7]
         irq_req <= irq_flag_reg;
      end
   end

   // baud counter held in reset while the port is off
   baud_gen #(
      .DIV_W(8)
   ) u_baud (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(uart_on_reg), // [RQ19]
      .high_speed(ctrl_b_reg.baud_high_speed), // [RQ8]
      .divisor(baud_divisor_reg),
      .os_tick(os_tick),
      .bit_tick(bit_tick)
   );

   // transmit shifter
   uart_tx u_tx (
      .clk(clk),
      .sys_rst(sys_rst),
      .active(tx_active),
      .bit_tick(bit_tick),
      .nine_bit(nine_bit_reg),
      .send_break(send_break_reg),
      .hold_valid(hold_valid_reg),
      .hold_word({tx_hold_ninth_reg, tx_hold_reg}),
      .take(tx_take),
      .busy(tx_busy),
      .line(tx_line)
   );
endmodule : uart_ctrl

// ### testbench/uart_ctrl_checker.sv
// checker: apb answer timing, idle transmit level, wake pulse
// assumes binding onto uart_ctrl, one clock, synchronous reset
`timescale 1ns/1ns
module uart_ctrl_checker import uart_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and power
   input wire pins_t pins,
   input wire logic sleep_mode,
   input wire logic wake_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // one wait state, answer stands a single cycle
   AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready) else $error("late answer");
   AST_PULSE: assert property (pready |=> !pready) else $error("answer held");
   AST_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("answer unasked");
   AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error");
   AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0000_0000) else $error("stray data");
   // first edge after reset excluded: line still settling
   AST_TX_REST: assert property (!pins.tx_oe && !$past(sys_rst) |-> pins.tx_out) else $error("idle low");
   AST_WAKE_PULSE: assert property (wake_req |=> !wake_req) else $error("wake held");
   AST_WAKE_SLEEP: assert property (wake_req |-> $past(sleep_mode)) else $error("wake awake");
   COV_ERR: cover property (pslverr);
   COV_WAKE: cover property (wake_req);
   COV_START: cover property (pins.tx_oe && $fell(pins.tx_out));
endmodule : uart_ctrl_checker

bind uart_ctrl uart_ctrl_checker u_uart_ctrl_checker (.clk(clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
   .sleep_mode(sleep_mode), .wake_req(wake_req));

// ### testbench/uart_peer.sv
// remote transceiver: drives the receive line, listens on transmit
// assumes pull-ups on both lines and one stop bit
`timescale 1ns/1ns
module uart_peer import uart_pkg::*; (
   // clock
   input wire logic clk,
   // lines
   input wire pins_t pins,
   output logic rx_pin
);
   // floated transmit pin reads high through the pull-up
   wire logic tx_line = pins.tx_oe ? pins.tx_out : 1'b1;
   initial rx_pin = 1'b1;
   // start low, data lsb first, stop high
   task automatic send(input logic [8:0] w, input int nb, input int per);
      int i;
      @(posedge clk);
      rx_pin <= 1'b0;
      repeat (per) @(posedge clk);
      for (i = 0; i < nb; i++) begin
         rx_pin <= w[i];
         repeat (per) @(posedge clk);
      end
      rx_pin <= 1'b1;
      repeat (per) @(posedge clk);
   endtask : send
   // bounded wait for a low stretch, then its length in clocks
   task automatic low_len(output int n);
      int t;
      n = 0;
      for (t = 0; t < 4000 && tx_line !== 1'b0; t++) @(posedge clk);
      while (tx_line === 1'b0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
   endtask : low_len
   // start bit measured; bit zero must be one so its end shows
   task automatic grab(output logic [8:0] w, output int n, input int nb, input int per);
      int t;
      w = 9'h000;
      low_len(n);
      repeat (per / 2) @(posedge clk);
      for (t = 0; t < nb; t++) begin
         w[t] = tx_line;
         repeat (per) @(posedge clk);
      end
   endtask : grab
endmodule : uart_peer

// ### testbench/uart_ctrl_tb.sv
// testbench for the serial port control block: apb tasks, scenarios
// assumes uart_peer stands for the remote transceiver
`timescale 1ns/1ns
`include "uart_map.svh"
module uart_ctrl_tb import uart_pkg::*;;
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic sleep_mode = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, wake_req, irq_req, rx_pin, se;
   pins_t pins;
   logic [31:0] rd;
   logic [8:0] w;
   int n;
   int err_count = 0;
   int cmp_count = 0;
   int wake_cnt = 0;
   always #5 clk = ~clk;
   // count wake pulses seen at the port
   always @(posedge clk) if (wake_req === 1'b1) wake_cnt++;
   uart_ctrl u_uart_ctrl (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_pin(rx_pin), .pins(pins), .sleep_mode(sleep_mode), .wake_req(wake_req), .irq_req(irq_req));
   uart_peer u_uart_peer (.clk(clk), .pins(pins), .rx_pin(rx_pin));
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, request held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge clk);
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      for (t = 0; t < 20; t++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (t == 20) begin
         err_count++;
         conclude();
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h00_0000, d});
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, ZERO);
      chk(rd, {24'h00_0000, e});
   endtask : rdc
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      // reset values, a hole in the map, full divisor range
      rdc(`OFS_CTRL_A, 8'h00);
      rdc(`OFS_CTRL_B, 8'h00);
      xfer(1'b0, 8'h18, ZERO);
      chk({31'h0, se}, ONE);
      wr(`OFS_BAUD, 8'hFF);
      rdc(`OFS_BAUD, 8'hFF);
      // low speed, divisor zero: 64 clocks a bit, no irq enabled
      wr(`OFS_BAUD, 8'h00);
      wr(`OFS_CTRL_A, 8'h80);
      wr(`OFS_CTRL_B, 8'hC0);
      fork
         u_uart_peer.grab(w, n, 8, 64);
         wr(`OFS_DATA, 8'hA5);
      join
      chk(n, 64);
      chk({23'h0, w}, 32'h0000_00A5);
      chk({31'h0, irq_req}, ZERO);
      // high speed, divisor one: 32 clocks a bit, nine data bits
      wr(`OFS_BAUD, 8'h01);
      wr(`OFS_CTRL_A, 8'hC1);
      wr(`OFS_CTRL_B, 8'hE1);
      fork
         u_uart_peer.grab(w, n, 9, 32);
         wr(`OFS_DATA, 8'hA5);
      join
      chk(n, 32);
      chk({23'h0, w}, 32'h0000_01A5);
      repeat (64) @(posedge clk);
      chk({31'h0, irq_req}, ONE);
      wr(`OFS_IRQ, 8'h01);
      // nine-bit reception, rx irq masked
      u_uart_peer.send(9'h15A, 9, 32);
      rdc(`OFS_STATUS, 8'h0F);
      rdc(`OFS_CTRL_A, 8'hC2);
      rdc(`OFS_DATA, 8'h5A);
      chk({31'h0, irq_req}, ZERO);
      // address detect: bit seven marks an address word
      wr(`OFS_CTRL_A, 8'h80);
      wr(`OFS_CTRL_B, 8'hF6);
      u_uart_peer.send(9'h012, 8, 32);
      rdc(`OFS_STATUS, 8'h0B);
      chk({31'h0, irq_req}, ZERO);
      u_uart_peer.send(9'h092, 8, 32);
      rdc(`OFS_DATA, 8'h92);
      chk({31'h0, irq_req}, ONE);
      wr(`OFS_IRQ, 8'h01);
      // break must outlast thirteen bits and last until cleared
      fork
         u_uart_peer.low_len(n);
         begin
            wr(`OFS_CTRL_A, 8'h84);
            repeat (640) @(posedge clk);
            wr(`OFS_CTRL_A, 8'h80);
         end
      join
      chk(n >= 576 && n <= 704, ONE);
      // end of the break frame raises idle, idle and rx irqs enabled
      repeat (4) @(posedge clk);
      chk({31'h0, irq_req}, ONE);
      // tx enable dropped mid-frame, then the port switched off
      wr(`OFS_DATA, 8'h00);
      repeat (100) @(posedge clk);
      wr(`OFS_CTRL_B, 8'h74);
      repeat (3) @(posedge clk);
      chk({30'h0, pins.tx_oe, pins.rx_ctl}, ONE);
      wr(`OFS_CTRL_A, 8'h00);
      rdc(`OFS_STATUS, 8'h0B);
      rdc(`OFS_CTRL_B, 8'h34);
      chk({30'h0, pins.tx_oe, pins.rx_ctl}, ZERO);
      // receive falling edges wake while asleep only when enabled
      sleep_mode <= 1'b1;
      wr(`OFS_CTRL_B, 8'h08);
      wake_cnt = 0;
      u_uart_peer.send(9'h0A5, 8, 32);
      chk(wake_cnt > 0, ONE);
      wr(`OFS_CTRL_B, 8'h00);
      wake_cnt = 0;
      u_uart_peer.send(9'h0A5, 8, 32);
      chk(wake_cnt, ZERO);
      conclude();
   end
endmodule : uart_ctrl_tb
